// file: verilog/status_output_pin_select.sv
// Purpose: Selects one internal radio signal onto each of three output pins.
// Assumes: RADIO inputs are synchronous to SYS_CLK (the crystal clock).
// Notes:   Registers over APB; pins are split into data and output enable.
//
// Functional notes
// - Each pin picks its own signal independently
// - Pin b valid only while chip select high
// - Pin b high impedance after reset
// - Pin a outputs crystal clock / 192 after reset
// - Config 0x80 on pin a routes temperature sensor
// - Codes below 0x20 forced in sleep until ready
// - Codes 0x20 and above keep working in sleep
// - Code 0x2E is high impedance always
// - 0x00: receive FIFO at or above threshold
// - 0x01: threshold or packet end, until empty
// - 0x02: transmit FIFO at or above threshold
// - 0x04: receive overflow held until flush
// - 0x05: transmit underflow held until flush
// - 0x06: sync word until packet end or abort
// - 0x07: checksum good until first byte read
// - 0x08: preamble quality above threshold
// - 0x09: clear channel per mode setting
// - 0x0A: synthesizer lock detector output
// - 0x0B: synchronous serial clock output
// - 0x0C/0x0D: synchronous or asynchronous receive data
// - 0x0E: carrier sense above threshold
// - 0x0F: last checksum matched, cleared on receive
`timescale 1ns/1ps
module status_output_pin_select
   import pin_select_pkg::*;
(
   // Clock and reset
   input  wire logic          SYS_CLK,
   input  wire logic          RESET,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [7:0]    PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic               PREADY,
   output logic [31:0]        PRDATA,
   output logic               PSLVERR,
   // Radio core state
   input  wire radio_status_t RADIO,
   input  wire logic          SLEEP,
   input  wire logic          CHIP_READY_N,
   input  wire logic          SERIAL_CHIP_SELECT_N,
   // Output pins
   output logic               GP_OUT_PIN_A_O,
   output logic               GP_OUT_PIN_A_OE,
   output logic               GP_OUT_PIN_B_O,
   output logic               GP_OUT_PIN_B_OE,
   output logic               GP_OUT_PIN_C_O,
   output logic               GP_OUT_PIN_C_OE,
   output logic               TEMP_SENSOR_EN
);

   // ==========================================================
   // Registers and state
   logic [7:0]            pin_config [3];
   logic [22:0]           levels;
   logic [FLAG_COUNT-1:0] flags;
   logic [FLAG_COUNT-1:0] next_flags;
   logic [7:0]            div_count;
   logic                  div_clk;
   logic                  sleep_hold;
   logic [2:0]            pin_out;
   logic [2:0]            pin_oe;
   logic [2:0]            raw;
   logic [2:0]            next_out;
   logic [2:0]            next_oe;

   // ==========================================================
   // Bus decode
   wire       access  = PSEL && PENABLE;
   wire       commit  = access && PREADY;
   wire       do_wr   = commit && PWRITE;
   wire       hit_a   = (PADDR == PIN_A_CONFIG_ADDR);
   wire       hit_b   = (PADDR == PIN_B_CONFIG_ADDR);
   wire       hit_c   = (PADDR == PIN_C_CONFIG_ADDR);
   wire       hit_lv  = (PADDR == LEVELS_ADDR);
   wire       hit_st  = (PADDR == STATUS_ADDR);
   wire       mapped  = hit_a || hit_b || hit_c || hit_lv || hit_st;

   wire [7:0] cca_thr  = levels[LV_CCA_LSB +: 8];
   wire [7:0] cs_thr   = levels[LV_CS_LSB +: 8];
   wire [1:0] clear_channel_mode = levels[LV_MODE_LSB +: 2];
   wire [4:0] pq_thr   = levels[LV_PQT_LSB +: 5];

   // Status word: pin levels, enables, sleep hold and sticky flags
   wire [31:0] status_word = {17'h00000, flags, 1'b0, sleep_hold,
                              pin_oe, pin_out};

   wire [31:0] read_word =
      hit_a  ? {24'h000000, pin_config[0]} :
      hit_b  ? {24'h000000, pin_config[1]} :
      hit_c  ? {24'h000000, pin_config[2]} :
      hit_lv ? {9'h000, levels} :
      hit_st ? status_word : 32'h00000000;

   // APB answer one cycle into the access phase; registered outputs
   always_ff @(posedge SYS_CLK) begin
      if (RESET || !access || PREADY) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= 1'b1;
         PRDATA  <= PWRITE ? 32'h00000000 : read_word;
         PSLVERR <= !mapped;
      end
   end

   // Register writes take effect at the edge where PREADY is sampled
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         pin_config[0] <= PIN_A_CONFIG_RESET;
         pin_config[1] <= PIN_B_CONFIG_RESET;
         pin_config[2] <= PIN_C_CONFIG_RESET;
         levels        <= LEVELS_RESET;
      end else if (do_wr) begin
         if (hit_a)
            pin_config[0] <= PWDATA[7:0];
         if (hit_b)
            pin_config[1] <= PWDATA[7:0];
         if (hit_c)
            pin_config[2] <= PWDATA[7:0];
         if (hit_lv)
            levels <= PWDATA[22:0];
      end
   end

   // ==========================================================
   // Sticky event flags; a set in the same cycle as a clear wins
   assign next_flags[FL_RX_EOP] =
      (RADIO.rx_at_thresh || RADIO.end_of_packet) ||
      (flags[FL_RX_EOP] && !RADIO.rx_empty);
   assign next_flags[FL_TX_FULL] = RADIO.tx_full ||
      (flags[FL_TX_FULL] && RADIO.tx_at_thresh);
   assign next_flags[FL_RX_OVF] = RADIO.rx_overflow ||
      (flags[FL_RX_OVF] && !RADIO.rx_flush);
   assign next_flags[FL_TX_UNF] = RADIO.tx_underflow ||
      (flags[FL_TX_UNF] && !RADIO.tx_flush);
   assign next_flags[FL_SYNC] = RADIO.sync_word ||
      (flags[FL_SYNC] && !(RADIO.packet_end || RADIO.addr_fail ||
       RADIO.rx_overflow || RADIO.tx_underflow));
   assign next_flags[FL_CRC_PKT] = RADIO.crc_ok_packet ||
      (flags[FL_CRC_PKT] && !RADIO.rx_first_read);
   // A fresh comparison result beats the receive-entry clear
   assign next_flags[FL_CRC_MATCH] = RADIO.crc_match ||
      (flags[FL_CRC_MATCH] && !RADIO.rx_entry);

   always_ff @(posedge SYS_CLK) begin
      if (RESET)
         flags <= '0;
      else
         flags <= next_flags;
   end

   // ==========================================================
   // Crystal clock divider: toggle every 96 cycles for /192
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         div_count <= 8'h00;
         div_clk   <= 1'b0;
      end else if (div_count == DIV_HALF) begin
         div_count <= 8'h00;
         div_clk   <= !div_clk;
      end else begin
         div_count <= div_count + 8'h01;
      end
   end

   // Sleep forcing is held until the chip reports ready again
   always_ff @(posedge SYS_CLK) begin
      if (RESET)
         sleep_hold <= 1'b0;
      else if (SLEEP)
         sleep_hold <= 1'b1;
      else if (!CHIP_READY_N)
         sleep_hold <= 1'b0;
   end

   // ==========================================================
   // Clear channel: rssi below threshold, qualified by mode
   wire rssi_low  = (RADIO.rssi < cca_thr);
   wire clear_ch  = (clear_channel_mode == CCA_ALWAYS) ? 1'b1 :
                    (clear_channel_mode == CCA_RSSI)   ? rssi_low :
                    (clear_channel_mode == CCA_NOT_RX) ? !RADIO.receiving :
                    (rssi_low && !RADIO.receiving);

   // Signal chosen by one selection code; unlisted codes drive low
   function automatic logic pick(input logic [5:0] sel);
      logic r;
      r = 1'b0;
      case (sel)
         SEL_RX_THRESH:   r = RADIO.rx_at_thresh;
         SEL_RX_EOP:      r = flags[FL_RX_EOP];
         SEL_TX_THRESH:   r = RADIO.tx_at_thresh;
         SEL_TX_FULL:     r = flags[FL_TX_FULL];
         SEL_RX_OVERFLOW: r = flags[FL_RX_OVF];
         SEL_TX_UNDERFL:  r = flags[FL_TX_UNF];
         SEL_SYNC_WORD:   r = flags[FL_SYNC];
         SEL_CRC_PACKET:  r = flags[FL_CRC_PKT];
         SEL_PREAMBLE_Q:
            r = (RADIO.preamble_quality > pq_thr);
         SEL_CLEAR_CHAN:  r = clear_ch;
         SEL_PLL_LOCK:    r = RADIO.pll_lock;
         SEL_SERIAL_CLK:  r = RADIO.serial_clk;
         SEL_SYNC_DATA:   r = RADIO.sync_data;
         SEL_ASYNC_DATA:  r = RADIO.async_data;
         SEL_CARRIER:     r = (RADIO.rssi > cs_thr);
         SEL_CRC_MATCH:   r = flags[FL_CRC_MATCH];
         SEL_CRYSTAL_OSC_DIV:    r = div_clk;
         default:         r = 1'b0;
      endcase
      return r;
   endfunction

   // Process form: reads of flags and radio inside pick count as inputs,
   // whereas a continuous call would only wake up when sel moves
   always_comb begin
      for (int k = 0; k < 3; k++)
         raw[k] = pick(pin_config[k][CFG_SEL_MSB:0]);
   end

   // ==========================================================
   // Per-pin selection, inversion, sleep forcing and enable
   for (genvar i = 0; i < 3; i++) begin : g_pin
      wire [5:0] sel    = pin_config[i][CFG_SEL_MSB:0];
      wire       inv    = pin_config[i][CFG_INVERT_BIT];
      wire       analog = (i == 0) && pin_config[i][CFG_ANALOG_BIT];
      // Pin b idles at the complement so the shared data line rests high
      wire       forced = sleep_hold && (sel < SEL_SLEEP_LIMIT);
      wire       rest   = (i == 1) ? !inv : inv;
      // Pin b gives the line to the serial port while selected
      wire       bus_on = (i != 1) || SERIAL_CHIP_SELECT_N;

      assign next_out[i] = forced ? rest : (raw[i] ^ inv);
      // Codes at 0x20 and up never see the forcing term
      assign next_oe[i]  = (sel != SEL_HIGH_Z) && !analog &&
                           bus_on;
   end

   // Pins and sensor enable are registered for clean edges
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         pin_out        <= 3'h0;
         pin_oe         <= 3'h0;
         TEMP_SENSOR_EN <= 1'b0;
      end else begin
         pin_out        <= next_out;
         pin_oe         <= next_oe;
         TEMP_SENSOR_EN <= pin_config[0][CFG_ANALOG_BIT];
      end
   end

   assign GP_OUT_PIN_A_O  = pin_out[0];
   assign GP_OUT_PIN_A_OE = pin_oe[0];
   assign GP_OUT_PIN_B_O  = pin_out[1];
   assign GP_OUT_PIN_B_OE = pin_oe[1];
   assign GP_OUT_PIN_C_O  = pin_out[2];
   assign GP_OUT_PIN_C_OE = pin_oe[2];

   // ==========================================================
   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   wire [5:0] sel_a = pin_config[0][CFG_SEL_MSB:0];
   wire       inv_a = pin_config[0][CFG_INVERT_BIT];

   sequence s_overflow;
      RADIO.rx_overflow;
   endsequence

   sequence s_flush_only;
      RADIO.rx_flush && !RADIO.rx_overflow;
   endsequence

   a_overflow_held: assert property (
      s_overflow ##1 (!RADIO.rx_flush)[*2] |=> flags[FL_RX_OVF])
      else $error("overflow flag dropped before flush");

   a_flush_clears: assert property (
      s_flush_only |=> !flags[FL_RX_OVF])
      else $error("overflow flag survived flush");

   a_clock_period: assert property (
      $rose(div_clk) |-> ##96 $fell(div_clk))
      else $error("divided clock half period is not 96 cycles");

   a_high_z_pin: assert property (
      pin_config[1][CFG_SEL_MSB:0] == SEL_HIGH_Z |=> !GP_OUT_PIN_B_OE)
      else $error("pin b driven while high impedance selected");

   a_chip_select: assert property (
      !SERIAL_CHIP_SELECT_N |=> !GP_OUT_PIN_B_OE)
      else $error("pin b driven while chip select low");

   a_sleep_force: assert property (
      sleep_hold && sel_a < SEL_SLEEP_LIMIT && !pin_config[0][7]
      |=> GP_OUT_PIN_A_O == $past(inv_a) && GP_OUT_PIN_A_OE)
      else $error("pin a not forced to invert value in sleep");

   a_sleep_clock: assert property (
      sleep_hold && sel_a == SEL_CRYSTAL_OSC_DIV
      |=> GP_OUT_PIN_A_O == ($past(div_clk) ^ $past(inv_a)))
      else $error("clock output stopped in sleep");

   a_temp_route: assert property (
      pin_config[0][CFG_ANALOG_BIT] |=> TEMP_SENSOR_EN && !GP_OUT_PIN_A_OE)
      else $error("temperature routing not applied");

   a_crc_hold: assert property (
      RADIO.crc_ok_packet ##1 !RADIO.rx_first_read |=> flags[FL_CRC_PKT])
      else $error("checksum flag dropped before first read");

   a_sync_abort: assert property (
      RADIO.addr_fail && !RADIO.sync_word |=> !flags[FL_SYNC])
      else $error("sync flag not cleared on address failure");

   a_invert_pin_c: assert property (
      !sleep_hold && pin_config[2][CFG_SEL_MSB:0] == SEL_PLL_LOCK
      |=> GP_OUT_PIN_C_O ==
          ($past(RADIO.pll_lock) ^ $past(pin_config[2][6])))
      else $error("pin c lock output not inverted per setting");

   a_full_release: assert property (
      flags[FL_TX_FULL] && !RADIO.tx_full && !RADIO.tx_at_thresh
      |=> !flags[FL_TX_FULL])
      else $error("full flag kept after drain below threshold");

   a_empty_release: assert property (
      RADIO.rx_empty && !RADIO.rx_at_thresh && !RADIO.end_of_packet
      |=> !flags[FL_RX_EOP])
      else $error("packet flag kept after receive fifo empty");

   a_sleep_release: assert property (
      !SLEEP && !CHIP_READY_N |=> !sleep_hold)
      else $error("sleep forcing kept after chip ready");

   a_float_pin_c: assert property (
      pin_config[2][CFG_SEL_MSB:0] == SEL_HIGH_Z |=> !GP_OUT_PIN_C_OE)
      else $error("pin c driven while high impedance selected");

endmodule

// file: verilog/pin_select_pkg.sv
// Purpose: Shared constants and types for the status output pin selector.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes:   Pin configuration is {analog_enable, invert, select[5:0]}.
package pin_select_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] PIN_A_CONFIG_ADDR = 8'h00;
   localparam logic [7:0] PIN_B_CONFIG_ADDR = 8'h04;
   localparam logic [7:0] PIN_C_CONFIG_ADDR = 8'h08;
   localparam logic [7:0] LEVELS_ADDR       = 8'h0C;
   localparam logic [7:0] STATUS_ADDR       = 8'h10;

   // ==========================================================
   // Configuration field layout
   localparam int CFG_SEL_MSB    = 5;
   localparam int CFG_INVERT_BIT = 6;
   localparam int CFG_ANALOG_BIT = 7;

   // ==========================================================
   // Reset values: pin a clocks the host, pin b leaves the bus alone
   localparam logic [7:0] PIN_A_CONFIG_RESET = 8'h3F;
   localparam logic [7:0] PIN_B_CONFIG_RESET = 8'h2E;
   localparam logic [7:0] PIN_C_CONFIG_RESET = 8'h2E;
   localparam logic [22:0] LEVELS_RESET      = 23'h000000;

   // ==========================================================
   // Levels register fields
   localparam int LV_CCA_LSB  = 0;
   localparam int LV_CS_LSB   = 8;
   localparam int LV_MODE_LSB = 16;
   localparam int LV_PQT_LSB  = 18;

   // ==========================================================
   // Selection codes
   localparam logic [5:0] SEL_RX_THRESH   = 6'h00;
   localparam logic [5:0] SEL_RX_EOP      = 6'h01;
   localparam logic [5:0] SEL_TX_THRESH   = 6'h02;
   localparam logic [5:0] SEL_TX_FULL     = 6'h03;
   localparam logic [5:0] SEL_RX_OVERFLOW = 6'h04;
   localparam logic [5:0] SEL_TX_UNDERFL  = 6'h05;
   localparam logic [5:0] SEL_SYNC_WORD   = 6'h06;
   localparam logic [5:0] SEL_CRC_PACKET  = 6'h07;
   localparam logic [5:0] SEL_PREAMBLE_Q  = 6'h08;
   localparam logic [5:0] SEL_CLEAR_CHAN  = 6'h09;
   localparam logic [5:0] SEL_PLL_LOCK    = 6'h0A;
   localparam logic [5:0] SEL_SERIAL_CLK  = 6'h0B;
   localparam logic [5:0] SEL_SYNC_DATA   = 6'h0C;
   localparam logic [5:0] SEL_ASYNC_DATA  = 6'h0D;
   localparam logic [5:0] SEL_CARRIER     = 6'h0E;
   localparam logic [5:0] SEL_CRC_MATCH   = 6'h0F;
   localparam logic [5:0] SEL_SLEEP_LIMIT = 6'h20;
   localparam logic [5:0] SEL_HIGH_Z      = 6'h2E;
   localparam logic [5:0] SEL_CRYSTAL_OSC_DIV    = 6'h3F;

   // ==========================================================
   // Clock divider: crystal_osc / 192, toggled every half period
   localparam int            CRYSTAL_OSC_DIVIDE = 192;
   localparam logic [7:0]    DIV_HALF    = 8'(CRYSTAL_OSC_DIVIDE / 2 - 1);

   // ==========================================================
   // Sticky flag indices
   localparam int FL_RX_EOP    = 0;
   localparam int FL_TX_FULL   = 1;
   localparam int FL_RX_OVF    = 2;
   localparam int FL_TX_UNF    = 3;
   localparam int FL_SYNC      = 4;
   localparam int FL_CRC_PKT   = 5;
   localparam int FL_CRC_MATCH = 6;
   localparam int FLAG_COUNT   = 7;

   // Clear channel modes
   localparam logic [1:0] CCA_ALWAYS    = 2'h0;
   localparam logic [1:0] CCA_RSSI      = 2'h1;
   localparam logic [1:0] CCA_NOT_RX    = 2'h2;

   // Radio core status carried into the selector
   typedef struct packed {
      logic       rx_at_thresh;
      logic       rx_empty;
      logic       end_of_packet;
      logic       tx_at_thresh;
      logic       tx_full;
      logic       rx_overflow;
      logic       rx_flush;
      logic       tx_underflow;
      logic       tx_flush;
      logic       sync_word;
      logic       packet_end;
      logic       addr_fail;
      logic       crc_ok_packet;
      logic       rx_first_read;
      logic       crc_match;
      logic       rx_entry;
      logic       receiving;
      logic       pll_lock;
      logic       serial_clk;
      logic       sync_data;
      logic       async_data;
      logic [7:0] rssi;
      logic [4:0] preamble_quality;
   } radio_status_t;

endpackage

// file: test/host_pin_reader.sv
// Purpose: Host side that reads the three status pins.
// Assumes: Each pin comes as data plus an output enable.
// Notes:   A released pin floats to the inverse of its last level.
`timescale 1ns/1ps
module host_pin_reader (
   // Clock
   input  wire logic       clk,
   // Device pins
   input  wire logic [2:0] pin_o,
   input  wire logic [2:0] pin_oe,
   input  wire logic       cs_n,
   // Host view
   output logic [2:0]      level,
   output logic            pin_b_seen,
   output int              lock_rises
);
   logic [2:0] last;
   logic       prev_c;
   // =========================================================
   // Wire level: a stale value must never pass for a driven one
   assign level = (pin_oe & pin_o) | (~pin_oe & ~last);
   // Start state
   initial begin
      last = 3'h0;
      prev_c = 1'b1;  // A released pin idles high, so no false rise
      pin_b_seen = 1'b0;
      lock_rises = 0;
   end
   // Host sampling; pin b shares the serial output, so gate it
   always @(posedge clk) begin
      last <= (pin_oe & pin_o) | (~pin_oe & last);
      prev_c <= level[2];
      if (cs_n) begin
         pin_b_seen <= level[1];
      end
      if (level[2] && !prev_c) begin
         lock_rises <= lock_rises + 1;
      end
   end
endmodule

// file: test/status_output_pin_select_tb_top.sv
// Purpose: Self-checking bench for the status pin selector.
// Assumes: Pins settle within 3 cycles of their cause.
// Notes:   Pin levels are read through the host model.
`timescale 1ns/1ps
module status_output_pin_select_tb_top;
   import pin_select_pkg::*;
   logic          sys_clk = 1'b0;
   logic          reset = 1'b1;
   logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0, rdata;
   logic          pready, pslverr, err, temp_en, pin_b_seen;
   logic [31:0]   prdata;
   radio_status_t radio = '0;
   logic          sleep = 1'b0, chip_ready_n = 1'b0, cs_n = 1'b1;
   wire  [2:0]    pin_o, pin_oe, level;
   int            lock_rises, n_mismatch = 0, num_checks = 0;
   int            cycles = 0;
   logic [5:0]    lv_codes [9] = '{SEL_RX_THRESH, SEL_TX_THRESH,
      SEL_PREAMBLE_Q, SEL_CLEAR_CHAN, SEL_PLL_LOCK, SEL_SERIAL_CLK,
      SEL_SYNC_DATA, SEL_ASYNC_DATA, SEL_CARRIER};
   logic [5:0]    st_code [9] = '{6'h04, 6'h05, 6'h06, 6'h06, 6'h06,
      6'h07, 6'h0F, 6'h01, 6'h06};
   int            st_set [9] = '{0, 2, 4, 4, 4, 7, 9, 11, 4};
   int            st_clr [9] = '{1, 3, 5, 6, 0, 8, 10, 12, 2};

   // =========================================================
   // Instances
   status_output_pin_select status_output_pin_select_i (
      .SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .RADIO(radio), .SLEEP(sleep),
      .CHIP_READY_N(chip_ready_n), .SERIAL_CHIP_SELECT_N(cs_n),
      .GP_OUT_PIN_A_O(pin_o[0]), .GP_OUT_PIN_A_OE(pin_oe[0]),
      .GP_OUT_PIN_B_O(pin_o[1]), .GP_OUT_PIN_B_OE(pin_oe[1]),
      .GP_OUT_PIN_C_O(pin_o[2]), .GP_OUT_PIN_C_OE(pin_oe[2]),
      .TEMP_SENSOR_EN(temp_en));
   host_pin_reader host_pin_reader_i (
      .clk(sys_clk), .pin_o(pin_o), .pin_oe(pin_oe), .cs_n(cs_n),
      .level(level), .pin_b_seen(pin_b_seen),
      .lock_rises(lock_rises));

   // Clock and hang guard; the run needs well under 5000 cycles
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         stop_test();
      end
   end

   // =========================================================
   // Tasks
   task automatic stop_test();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_word(input string what, input logic [31:0] e,
                           input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // One APB transfer; the request stands until pready is sampled
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // Only the bench timeout ends a hang; the answer is due at edge 2
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      chk_word("pready_wait", 32'd2, 32'(n));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string what, input logic [7:0] a,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_word(what, e, rdata);
   endtask
   // Level source behind each continuous code
   task automatic set_src(input logic [5:0] code, input logic v);
      case (code)
         SEL_RX_THRESH:  radio.rx_at_thresh <= v;
         SEL_TX_THRESH:  radio.tx_at_thresh <= v;
         SEL_PREAMBLE_Q: radio.preamble_quality <= v ? 5'h0B : 5'h0A;
         SEL_CLEAR_CHAN: radio.rssi <= v ? 8'h3F : 8'h40;
         SEL_PLL_LOCK:   radio.pll_lock <= v;
         SEL_SERIAL_CLK: radio.serial_clk <= v;
         SEL_SYNC_DATA:  radio.sync_data <= v;
         SEL_ASYNC_DATA: radio.async_data <= v;
         SEL_CARRIER:    radio.rssi <= v ? 8'h41 : 8'h40;
         default:        ;
      endcase
   endtask
   // One-cycle radio events by index
   task automatic pulse(input int idx);
      for (int v = 1; v >= 0; v--) begin
         case (idx)
            0:  radio.rx_overflow <= v[0];
            1:  radio.rx_flush <= v[0];
            2:  radio.tx_underflow <= v[0];
            3:  radio.tx_flush <= v[0];
            4:  radio.sync_word <= v[0];
            5:  radio.packet_end <= v[0];
            6:  radio.addr_fail <= v[0];
            7:  radio.crc_ok_packet <= v[0];
            8:  radio.rx_first_read <= v[0];
            9:  radio.crc_match <= v[0];
            10: radio.rx_entry <= v[0];
            11: radio.end_of_packet <= v[0];
            13: radio.tx_full <= v[0];
            default: radio.rx_empty <= v[0];
         endcase
         @(posedge sys_clk);
      end
   endtask

   // =========================================================
   // Main sequence
   initial begin
      int n;
      ticks(6);
      reset <= 1'b0;
      ticks(2);
      chk_bit("oe_a", 1'b1, pin_oe[0]);
      chk_bit("oe_b", 1'b0, pin_oe[1]);
      rd("cfg_a", PIN_A_CONFIG_ADDR, 32'h0000003F);
      rd("cfg_b", PIN_B_CONFIG_ADDR, 32'h0000002E);
      rd("unmapped", 8'h14, 32'h00000000);
      chk_bit("slverr", 1'b1, err);
      n = 0;
      while (level[0] !== 1'b1 && n < 300) begin
         ticks(1);
         n++;
      end
      n = 0;
      while (level[0] === 1'b1 && n < 300) begin
         ticks(1);
         n++;
      end
      chk_word("div_half", 32'd96, 32'(n));
      wr(LEVELS_ADDR, 32'h00294040);
      rd("levels", LEVELS_ADDR, 32'h00294040);
      // Continuous codes on pin c, plain and inverted
      for (int i = 0; i < 9; i++) begin
         for (int inv = 0; inv < 2; inv++) begin
            wr(PIN_C_CONFIG_ADDR, {25'h0, inv[0], lv_codes[i]});
            set_src(lv_codes[i], 1'b1);
            ticks(3);
            chk_bit("c_high", ~inv[0], level[2]);
            set_src(lv_codes[i], 1'b0);
            ticks(3);
            chk_bit("c_low", inv[0], level[2]);
         end
      end
      // Held flags on pin a; first drain the packet flag code 0x00 left
      pulse(12);
      for (int i = 0; i < 9; i++) begin
         wr(PIN_A_CONFIG_ADDR, {26'h0, st_code[i]});
         ticks(3);
         chk_bit("st_idle", 1'b0, level[0]);
         pulse(st_set[i]);
         ticks(3);
         chk_bit("st_set", 1'b1, level[0]);
         ticks(5);
         chk_bit("st_held", 1'b1, level[0]);
         pulse(st_clr[i]);
         ticks(3);
         chk_bit("st_clear", 1'b0, level[0]);
      end
      wr(PIN_A_CONFIG_ADDR, {26'h0, SEL_TX_FULL});
      set_src(SEL_TX_THRESH, 1'b1);
      pulse(13);
      ticks(3);
      chk_bit("full_held", 1'b1, level[0]);
      set_src(SEL_TX_THRESH, 1'b0);
      ticks(3);
      chk_bit("full_clear", 1'b0, level[0]);
      // Let pin c settle low before lock rises
      wr(PIN_C_CONFIG_ADDR, {26'h0, SEL_PLL_LOCK});
      ticks(3);
      n = lock_rises;
      set_src(SEL_PLL_LOCK, 1'b1);
      ticks(3);
      chk_word("lock_irq", 32'(n + 1), 32'(lock_rises));
      // Sleep forcing and the chip-ready release
      wr(PIN_A_CONFIG_ADDR, {26'h0, SEL_CRYSTAL_OSC_DIV});
      wr(PIN_B_CONFIG_ADDR, {26'h0, SEL_RX_THRESH});
      wr(PIN_C_CONFIG_ADDR, {26'h0, SEL_TX_THRESH});
      set_src(SEL_TX_THRESH, 1'b1);
      ticks(3);
      chk_bit("b_awake", 1'b0, pin_b_seen);
      chk_bit("c_awake", 1'b1, level[2]);
      sleep <= 1'b1;
      chip_ready_n <= 1'b1;
      // The host's latch of pin b lags the pin by one edge
      ticks(4);
      chk_bit("b_sleep", 1'b1, pin_b_seen);
      chk_bit("c_sleep", 1'b0, level[2]);
      chk_bit("a_sleep_oe", 1'b1, pin_oe[0]);
      sleep <= 1'b0;
      ticks(3);
      chk_bit("b_hold", 1'b1, pin_b_seen);
      chip_ready_n <= 1'b0;
      ticks(4);
      chk_bit("b_ready", 1'b0, pin_b_seen);
      chk_bit("c_ready", 1'b1, level[2]);
      // Pin b source goes high while selected: the host must not see it
      cs_n <= 1'b0;
      set_src(SEL_RX_THRESH, 1'b1);
      ticks(3);
      chk_bit("b_cs_oe", 1'b0, pin_oe[1]);
      chk_bit("b_cs_seen", 1'b0, pin_b_seen);
      cs_n <= 1'b1;
      ticks(4);
      chk_bit("b_cs_back", 1'b1, pin_b_seen);
      // Inverted low-code pin a forced to its invert bit in sleep
      wr(PIN_A_CONFIG_ADDR, {25'h0, 1'b1, SEL_RX_THRESH});
      wr(PIN_C_CONFIG_ADDR, {26'h0, SEL_HIGH_Z});
      sleep <= 1'b1;
      chip_ready_n <= 1'b1;
      ticks(3);
      chk_bit("a_sleep_inv", 1'b1, level[0]);
      chk_bit("c_sleep_oe", 1'b0, pin_oe[2]);
      sleep <= 1'b0;
      chip_ready_n <= 1'b0;
      ticks(3);
      chk_bit("a_ready_inv", 1'b0, level[0]);
      wr(PIN_A_CONFIG_ADDR, 32'h00000080);
      ticks(2);
      chk_bit("temp_en", 1'b1, temp_en);
      chk_bit("a_analog_oe", 1'b0, pin_oe[0]);
      stop_test();
   end
endmodule
